/* shared/cie_pkg.sv */
// constants, opcode fields and state codes of the instruction execution core
// assumes program and data memories answer a read in the cycle the request shows
//
// Behaviour
// - add, and, compare, subtract use the accumulator and a memory or immediate byte
// - invert, rotate-through-carry and shift-left act on the accumulator only
// - conditional branches jump only when their condition holds, else fall through
// - flag branches carry 5-bit signed displacement, reach -15 to +16
// - bit-test branches carry 8-bit displacement, reach -126 to +129
// - bit-test branch copies the tested bit into carry, zero untouched
// - bit set/clear reach any data bit, two bytes, four cycles, flags kept
// - bit group selects the bit inside the byte with a 3-bit index
// - with the watchdog selected a stop instruction runs as a wait
// - absolute jump and call carry a 12-bit target address
package cie_pkg;

  // ***************************************************************
  // addresses and lengths
  // ***************************************************************
  localparam logic [11:0] RESET_PC   = 12'h000;
  localparam logic [7:0]  PTR_X_ADDR = 8'h80;
  localparam logic [7:0]  PTR_Y_ADDR = 8'h81;
  localparam logic [11:0] LEN1       = 12'h001;
  localparam logic [11:0] LEN2       = 12'h002;
  localparam logic [11:0] LEN3       = 12'h003;
  localparam logic [11:0] PCR_BIAS   = 12'h001;
  localparam logic [11:0] BTB_BIAS   = 12'h002;

  // ***************************************************************
  // opcode low nibble groups
  // ***************************************************************
  localparam logic [3:0] OPL_CALL    = 4'h1;
  localparam logic [3:0] OPL_BTB     = 4'h3;
  localparam logic [3:0] OPL_ALU_IND = 4'h7;
  localparam logic [3:0] OPL_JP      = 4'h9;
  localparam logic [3:0] OPL_BIT     = 4'hB;
  localparam logic [3:0] OPL_INH     = 4'hD;
  localparam logic [3:0] OPL_ALU_DIR = 4'hF;

  localparam logic [2:0] PCR_NZ = 3'h0;
  localparam logic [2:0] PCR_NC = 3'h2;
  localparam logic [2:0] PCR_Z  = 3'h4;
  localparam logic [2:0] PCR_C  = 3'h6;

  localparam logic [3:0] INH_NOP  = 4'h0;
  localparam logic [3:0] INH_RET  = 4'h1;
  localparam logic [3:0] INH_RETURN_FROM_INTERRUPT = 4'h2;
  localparam logic [3:0] INH_STOP = 4'h3;
  localparam logic [3:0] INH_WAIT = 4'h4;
  localparam logic [3:0] INH_INV  = 4'h5;
  localparam logic [3:0] INH_RLC  = 4'h6;
  localparam logic [3:0] INH_SLA  = 4'h7;

  // ***************************************************************
  // alu functions
  // ***************************************************************
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_AND = 3'h1;
  localparam logic [2:0] ALU_CMP = 3'h2;
  localparam logic [2:0] ALU_SUB = 3'h3;
  localparam logic [2:0] ALU_INV = 3'h4;
  localparam logic [2:0] ALU_RLC = 3'h5;
  localparam logic [2:0] ALU_SLA = 3'h6;

  // ***************************************************************
  // instruction lengths in clock cycles
  // ***************************************************************
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_LONG  = 3'h4;
  localparam logic [2:0] CYC_BTB   = 3'h5;
  localparam logic [2:0] CYC_WR    = 3'h3;

  typedef enum logic [6:0] {
    S_FETCH = 7'h01,
    S_DEC   = 7'h02,
    S_PTR   = 7'h04,
    S_MEM   = 7'h08,
    S_WR    = 7'h10,
    S_PAD   = 7'h20,
    S_HALT  = 7'h40
  } cie_state_t;

endpackage : cie_pkg

/* tb/cie_core_tb.sv */
// self-checking bench of the execution core: small programs, run until halt
// assumes the core halts on a stop opcode, which fills all unused program space
`timescale 1ns/10ps
module cie_core_tb;
  import cie_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, int_entry = 1'b0, wdg = 1'b0, wake = 1'b0;
  logic pm_rd, dm_rd, dm_wr, push, pop, stop, wait_s, zero, carry;
  logic [11:0] pm_addr, push_data, top, pc;
  logic [7:0]  pm_data, dm_addr, dm_wdata, dm_rdata, acc, a, b, v, rr, ptr;
  logic [8:0]  r;
  logic [2:0]  fn, k;
  logic [1:0]  md, fl, cnd;
  logic        w, s, pol, tk;
  int          bad_count = 0, checks_done = 0, i;

  always #5 clk = ~clk;

  cie_core cie_core_inst (.REF_CLK_I(clk), .RST_B_I(rst_b), .PM_ADDR_O(pm_addr),
    .PM_RD_O(pm_rd), .PM_DATA_I(pm_data), .DM_ADDR_O(dm_addr), .DM_RD_O(dm_rd),
    .DM_WR_O(dm_wr), .DM_WDATA_O(dm_wdata), .DM_RDATA_I(dm_rdata), .STACK_PUSH_O(push),
    .STACK_POP_O(pop), .STACK_WDATA_O(push_data), .STACK_TOP_I(top),
    .INT_ENTRY_I(int_entry), .WDG_SEL_I(wdg), .WAKE_I(wake), .STOP_O(stop),
    .WAIT_O(wait_s), .ACC_O(acc), .ZERO_O(zero), .CARRY_O(carry));

  cie_mem_model mm (.clk_i(clk), .pm_addr_i(pm_addr), .pm_rd_i(pm_rd), .pm_data_o(pm_data),
    .dm_addr_i(dm_addr), .dm_rd_i(dm_rd), .dm_wr_i(dm_wr), .dm_wdata_i(dm_wdata),
    .dm_rdata_o(dm_rdata), .push_i(push), .pop_i(pop), .push_data_i(push_data),
    .top_o(top));

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic close_out();
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic em(input logic [7:0] d);
    mm.pm[pc] = d;
    pc        = pc + 12'h001;
  endtask : em

  // marker sets bit n of F0h; it leaves the flags alone so they can be checked after
  task automatic mark(input logic [2:0] n);
    em({n[0], n[1], n[2], 1'b1, 4'hB});
    em(8'hF0);
  endtask : mark

  task automatic clr();
    foreach (mm.pm[j])
      mm.pm[j] = 8'h3D;
    mm.dm[8'hF0] = 8'h00;
    pc           = 12'h000;
  endtask : clr

  task automatic run(input logic wd, input logic irq);
    int n;
    @(posedge clk);
    #1 rst_b = 1'b0;
    wdg   = wd;
    mm.sp = 3'h0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    int_entry = irq;
    @(posedge clk);
    #1 int_entry = 1'b0;
    n = 0;
    while (!(stop === 1'b1 || wait_s === 1'b1) && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 300)
    begin
      bad_count++;
      close_out();
    end
    #1;
    chk_flag(stop, !wd);
    chk_flag(wait_s, wd);
  endtask : run

  // carry is the borrow for compare and subtract; rotate takes ci as the old carry
  function automatic logic [8:0] f_alu(input logic [2:0] f, input logic [7:0] x,
                                       input logic [7:0] y, input logic ci);
    case (f)
      ALU_ADD: return {1'b0, x} + {1'b0, y};
      ALU_AND: return {1'b0, x & y};
      ALU_CMP, ALU_SUB: return {x < y, x - y};
      ALU_INV: return {x[7], ~x};
      ALU_RLC: return {x, ci};
      default: return {x, 1'b0};
    endcase
  endfunction : f_alu

  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out();
  end

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial
  begin
    i = $urandom(32'h49C8CB89);
    for (i = 0; i < 21; i++)
    begin
      fn  = 3'(i % 7);
      md  = 2'($urandom_range(0, 2));
      a   = 8'($urandom);
      b   = (i < 7) ? a : 8'($urandom);
      ptr = 8'($urandom_range(16, 127));
      clr();
      mm.dm[ptr]        = b;
      mm.dm[PTR_X_ADDR] = ptr;
      mm.dm[PTR_Y_ADDR] = ptr;
      em(8'h1F);
      em(a);
      // compare against ptr leaves acc alone and gives the op a known carry in
      em(8'h5F);
      em(ptr);
      if (fn > ALU_SUB)
        em({4'(fn) + 4'h1, 4'hD});
      else if (md == 2'h2)
        em({1'b0, fn[1:0], i[0], 4'h7});
      else
      begin
        em({1'b0, fn[1:0], md == 2'h0, 4'hF});
        em(md == 2'h0 ? b : ptr);
      end
      run(1'($urandom), 1'b0);
      r = f_alu(fn, a, b, a < ptr);
      chk_val(12'(acc), 12'(fn == ALU_CMP ? a : r[7:0]));
      chk_flag(zero, r[7:0] == 8'h00);
      chk_flag(carry, r[8]);
    end
    for (i = 0; i < 16; i++)
    begin
      cnd = i[1:0];
      fl  = i[3:2];
      a   = fl[0] ? 8'h80 : {7'h00, !fl[1]};
      b   = a + {7'h00, fl == 2'h1};
      clr();
      em(8'h1F);
      em(a);
      em(8'h1F);
      em(b);
      em(8'hA9);
      em(8'h40);
      pc = 12'hA40;
      em({i[0] ? 5'h0F : 5'h10, cnd, 1'b0});
      mark(3'h0);
      pc = i[0] ? 12'hA50 : 12'hA31;
      mark(3'h1);
      run(1'($urandom), 1'b0);
      tk = (cnd[0] ? fl[0] : fl[1]) == cnd[1];
      chk_val(12'(mm.dm[8'hF0]), tk ? 12'h002 : 12'h001);
      chk_flag(zero, fl[1]);
      chk_flag(carry, fl[0]);
    end
    for (i = 0; i < 8; i++)
    begin
      k   = 3'($urandom);
      s   = 1'($urandom);
      pol = 1'($urandom);
      rr  = 8'($urandom_range(0, 127));
      v   = (i == 0) ? 8'hFF : 8'($urandom);
      a   = 8'($urandom_range(0, 1));
      clr();
      mm.dm[rr] = v;
      em(8'h1F);
      em(a);
      em({k[0], k[1], k[2], s, 4'hB});
      em(rr);
      em({k[0], k[1], k[2], pol, 4'h3});
      em(rr);
      em(i[0] ? 8'h7F : 8'h80);
      mark(3'h0);
      pc = i[0] ? 12'h085 : 12'hF86;
      mark(3'h1);
      run(1'($urandom), 1'b0);
      chk_val(12'(mm.dm[rr]), 12'(s ? v | (8'h01 << k) : v & ~(8'h01 << k)));
      chk_val(12'(mm.dm[8'hF0]), (s == pol) ? 12'h002 : 12'h001);
      chk_flag(carry, s);
      chk_flag(zero, a == 8'h00);
    end
    for (i = 0; i < 2; i++)
    begin
      clr();
      em(8'h1F);
      em(8'h80);
      em(8'h1F);
      em(8'h80);
      em(8'h11);
      em(8'h23);
      mark(3'h0);
      em(8'h3D);
      mark(3'h2);
      pc = 12'h123;
      em(i[0] ? 8'h2D : 8'h1D);
      run(1'b0, 1'b1);
      chk_val(12'(mm.dm[8'hF0]), 12'h001);
      chk_flag(zero, !i[0]);
      chk_flag(carry, !i[0]);
      // wake leaves the halt and runs on at the next byte: a second marker, then stop
      wake = 1'b1;
      @(posedge clk);
      #1 wake = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk_val(12'(mm.dm[8'hF0]), 12'h005);
      chk_flag(stop, 1'b1);
    end
    close_out();
  end
endmodule : cie_core_tb

/* tb/cie_mem_model.sv */
// program, data and stack memories that sit around the execution core
// assumes the bench loads both memories and clears sp before releasing reset
`timescale 1ns/10ps
module cie_mem_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] pm_addr_i,
  input  wire logic        pm_rd_i,
  output logic      [7:0]  pm_data_o,
  input  wire logic [7:0]  dm_addr_i,
  input  wire logic        dm_rd_i,
  input  wire logic        dm_wr_i,
  input  wire logic [7:0]  dm_wdata_i,
  output logic      [7:0]  dm_rdata_o,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [11:0] push_data_i,
  output logic      [11:0] top_o
);
  logic [7:0]  pm      [4096];
  logic [7:0]  dm      [256];
  logic [11:0] stk     [8];
  logic [2:0]  sp      = 3'h0;
  logic [7:0]  pm_last = 8'h00;
  logic [7:0]  dm_last = 8'h00;
  // outside a read the buses show the inverse of the last byte, so stale data cannot pass
  assign pm_data_o  = pm_rd_i ? pm[pm_addr_i] : ~pm_last;
  assign dm_rdata_o = dm_rd_i ? dm[dm_addr_i] : ~dm_last;
  assign top_o      = stk[sp - 3'h1];
  always @(posedge clk_i)
  begin
    if (pm_rd_i)
      pm_last <= pm[pm_addr_i];
    if (dm_rd_i)
      dm_last <= dm[dm_addr_i];
    if (dm_wr_i)
      dm[dm_addr_i] <= dm_wdata_i;
    if (push_i)
    begin
      stk[sp] <= push_data_i;
      sp      <= sp + 3'h1;
    end
    else if (pop_i)
      sp <= sp - 3'h1;
  end
endmodule : cie_mem_model

/* verilog/cie_alu.sv */
// accumulator alu of the execution core
// assumes the core picks the function and the second operand
`timescale 1ns/10ps
module cie_alu
  import cie_pkg::*;
(
  input  wire logic [2:0] fn_i,
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       c_i,
  output logic      [7:0] res_o,
  output logic            c_o,
  output logic            wr_o
);

  logic [8:0] res9;

  always_comb
  begin
    case (fn_i)
      ALU_ADD: res9 = {1'b0, a_i} + {1'b0, b_i};
      ALU_AND: res9 = {1'b0, a_i & b_i};
      ALU_CMP: res9 = {1'b0, a_i} - {1'b0, b_i};
      ALU_SUB: res9 = {1'b0, a_i} - {1'b0, b_i};
      ALU_INV: res9 = {a_i[7], ~a_i};
      ALU_RLC: res9 = {a_i, c_i};
      ALU_SLA: res9 = {a_i, 1'b0};
      default: res9 = {c_i, a_i};
    endcase
  end

  assign res_o = res9[7:0];
  assign c_o   = res9[8];
  // compare only sets flags, the accumulator keeps its value
  assign wr_o  = (fn_i != ALU_CMP);

endmodule : cie_alu

/* verilog/cie_core.sv */
// instruction fetch, decode and execute core
// assumes memories return read data in the cycle their request flop shows
// assumes stack and interrupt entry live outside and show the stack top
`timescale 1ns/10ps
module cie_core
  import cie_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_B_I,
  output logic      [11:0] PM_ADDR_O,
  output logic             PM_RD_O,
  input  wire logic [7:0]  PM_DATA_I,
  output logic      [7:0]  DM_ADDR_O,
  output logic             DM_RD_O,
  output logic             DM_WR_O,
  output logic      [7:0]  DM_WDATA_O,
  input  wire logic [7:0]  DM_RDATA_I,
  output logic             STACK_PUSH_O,
  output logic             STACK_POP_O,
  output logic      [11:0] STACK_WDATA_O,
  input  wire logic [11:0] STACK_TOP_I,
  input  wire logic        INT_ENTRY_I,
  input  wire logic        WDG_SEL_I,
  input  wire logic        WAKE_I,
  output logic             STOP_O,
  output logic             WAIT_O,
  output logic      [7:0]  ACC_O,
  output logic             ZERO_O,
  output logic             CARRY_O
);

  // ***************************************************************
  // state
  // ***************************************************************
  cie_state_t  state_ff;
  cie_state_t  nxt_state;
  logic [2:0]  cyc_ff;
  logic [2:0]  nxt_cyc;
  logic [2:0]  need_ff;
  logic [2:0]  nxt_need;
  logic [11:0] pc_ff;
  logic [11:0] nxt_pc;
  logic [7:0]  op_ff;
  logic [7:0]  nxt_op;
  logic [7:0]  acc_ff;
  logic [7:0]  nxt_acc;
  logic        z_ff;
  logic        nxt_z;
  logic        c_ff;
  logic        nxt_c;
  logic        sz_ff;
  logic        nxt_sz;
  logic        sc_ff;
  logic        nxt_sc;
  logic [11:0] pm_addr_ff;
  logic [11:0] nxt_pm_addr;
  logic        pm_rd_ff;
  logic        nxt_pm_rd;
  logic [7:0]  dm_addr_ff;
  logic [7:0]  nxt_dm_addr;
  logic        dm_rd_ff;
  logic        nxt_dm_rd;
  logic        dm_wr_ff;
  logic        nxt_dm_wr;
  logic [7:0]  dm_wdata_ff;
  logic [7:0]  nxt_dm_wdata;
  logic        push_ff;
  logic        nxt_push;
  logic        pop_ff;
  logic        nxt_pop;
  logic [11:0] stk_ff;
  logic [11:0] nxt_stk;
  logic        stop_ff;
  logic        nxt_stop;
  logic        wait_ff;
  logic        nxt_wait;
  logic        done;
  logic        exec;

  // ***************************************************************
  // decode
  // ***************************************************************
  logic [3:0]  lo;
  logic [3:0]  hi;
  logic        is_pcr;
  logic        pcr_ok;
  logic [11:0] pcr_tgt;
  logic [11:0] btb_tgt;
  logic [2:0]  bit_idx;
  logic [7:0]  bit_mask;
  logic        tested_bit;
  logic [7:0]  bit_wdata;
  logic [2:0]  alu_fn;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_wr;

  function automatic logic [2:0] cycles_of(input logic [7:0] op);
    logic [3:0] l;
    l = op[3:0];
    if (!op[0])
      cycles_of = CYC_SHORT;
    else if (l == OPL_BTB)
      cycles_of = CYC_BTB;
    else if (l == OPL_CALL || l == OPL_JP || l == OPL_BIT)
      cycles_of = CYC_LONG;
    else if (l == OPL_ALU_IND || l == OPL_ALU_DIR)
      cycles_of = CYC_LONG;
    else
      cycles_of = CYC_SHORT;
  endfunction : cycles_of

  assign lo         = op_ff[3:0];
  assign hi         = op_ff[7:4];
  assign is_pcr     = ~op_ff[0];
  // bit index order follows the opcode layout: opcode bits 7:5 reversed
  assign bit_idx    = {op_ff[5], op_ff[6], op_ff[7]};
  assign bit_mask   = 8'h01 << bit_idx;
  assign tested_bit = DM_RDATA_I[bit_idx];
  assign bit_wdata  = op_ff[4] ? (DM_RDATA_I | bit_mask) : (DM_RDATA_I & ~bit_mask);
  assign pcr_tgt    = pc_ff + {{7{op_ff[7]}}, op_ff[7:3]} + PCR_BIAS;
  assign btb_tgt    = pc_ff + {{4{PM_DATA_I[7]}}, PM_DATA_I} + BTB_BIAS;

  always_comb
  begin
    case (op_ff[2:0])
      PCR_NZ:  pcr_ok = ~z_ff;
      PCR_NC:  pcr_ok = ~c_ff;
      PCR_Z:   pcr_ok = z_ff;
      PCR_C:   pcr_ok = c_ff;
      default: pcr_ok = 1'b0;
    endcase
  end

  // ***************************************************************
  // alu
  // ***************************************************************
  always_comb
  begin
    if (lo == OPL_INH && hi == INH_INV)
      alu_fn = ALU_INV;
    else if (lo == OPL_INH && hi == INH_RLC)
      alu_fn = ALU_RLC;
    else if (lo == OPL_INH)
      alu_fn = ALU_SLA;
    else
      alu_fn = {1'b0, op_ff[6:5]};
  end

  // operand b is the immediate byte in decode, the data byte afterwards
  assign alu_b = (state_ff == S_MEM) ? DM_RDATA_I : PM_DATA_I;

  cie_alu u_alu (
    .fn_i  (alu_fn),
    .a_i   (acc_ff),
    .b_i   (alu_b),
    .c_i   (c_ff),
    .res_o (alu_res),
    .c_o   (alu_c),
    .wr_o  (alu_wr)
  );

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cyc      = cyc_ff + 3'h1;
    nxt_need     = need_ff;
    nxt_pc       = pc_ff;
    nxt_op       = op_ff;
    nxt_acc      = acc_ff;
    nxt_z        = z_ff;
    nxt_c        = c_ff;
    nxt_sz       = INT_ENTRY_I ? z_ff : sz_ff;
    nxt_sc       = INT_ENTRY_I ? c_ff : sc_ff;
    nxt_pm_addr  = pm_addr_ff;
    nxt_pm_rd    = 1'b0;
    nxt_dm_addr  = dm_addr_ff;
    nxt_dm_rd    = 1'b0;
    nxt_dm_wr    = 1'b0;
    nxt_dm_wdata = dm_wdata_ff;
    nxt_push     = 1'b0;
    nxt_pop      = 1'b0;
    nxt_stk      = stk_ff;
    nxt_stop     = stop_ff;
    nxt_wait     = wait_ff;
    done         = 1'b0;
    exec         = 1'b0;
    case (state_ff)
      S_FETCH:
      begin
        nxt_op      = PM_DATA_I;
        nxt_need    = cycles_of(PM_DATA_I);
        nxt_pm_addr = pc_ff + LEN1;
        nxt_pm_rd   = 1'b1;
        nxt_state   = S_DEC;
      end
      S_DEC:
      begin
        if (is_pcr)
        begin
          nxt_pc = pcr_ok ? pcr_tgt : pc_ff + LEN1;
          done   = 1'b1;
        end
        else if (lo == OPL_CALL || lo == OPL_JP)
        begin
          nxt_pc   = {hi, PM_DATA_I};
          nxt_push = (lo == OPL_CALL);
          nxt_stk  = pc_ff + LEN2;
          done     = 1'b1;
        end
        else if (lo == OPL_BTB)
        begin
          // data byte and displacement are fetched together
          nxt_dm_addr = PM_DATA_I;
          nxt_dm_rd   = 1'b1;
          nxt_pm_addr = pc_ff + LEN2;
          nxt_pm_rd   = 1'b1;
          nxt_state   = S_MEM;
        end
        else if (lo == OPL_BIT || (lo == OPL_ALU_DIR && !op_ff[4]))
        begin
          nxt_dm_addr = PM_DATA_I;
          nxt_dm_rd   = 1'b1;
          nxt_state   = S_MEM;
        end
        else if (lo == OPL_ALU_IND)
        begin
          nxt_dm_addr = op_ff[4] ? PTR_Y_ADDR : PTR_X_ADDR;
          nxt_dm_rd   = 1'b1;
          nxt_state   = S_PTR;
        end
        else if (lo == OPL_ALU_DIR)
        begin
          exec   = 1'b1;
          nxt_pc = pc_ff + LEN2;
          done   = 1'b1;
        end
        else
        begin
          // inherent group; undefined odd codes run as one-byte no-ops
          nxt_pc = pc_ff + LEN1;
          done   = 1'b1;
          if (lo == OPL_INH)
          begin
            case (hi)
              INH_RET:
              begin
                nxt_pc  = STACK_TOP_I;
                nxt_pop = 1'b1;
              end
              INH_RETURN_FROM_INTERRUPT:
              begin
                nxt_pc  = STACK_TOP_I;
                nxt_pop = 1'b1;
                nxt_z   = sz_ff;
                nxt_c   = sc_ff;
              end
              INH_STOP:
              begin
                nxt_stop  = ~WDG_SEL_I;
                nxt_wait  = WDG_SEL_I;
                nxt_state = S_HALT;
                done      = 1'b0;
              end
              INH_WAIT:
              begin
                nxt_wait  = 1'b1;
                nxt_state = S_HALT;
                done      = 1'b0;
              end
              INH_INV, INH_RLC, INH_SLA: exec = 1'b1;
              default: exec = 1'b0;
            endcase
          end
        end
      end
      S_PTR:
      begin
        nxt_dm_addr = DM_RDATA_I;
        nxt_dm_rd   = 1'b1;
        nxt_state   = S_MEM;
      end
      S_MEM:
      begin
        if (lo == OPL_BTB)
        begin
          nxt_c  = tested_bit;
          nxt_pc = (tested_bit == op_ff[4]) ? btb_tgt : pc_ff + LEN3;
          done   = 1'b1;
        end
        else if (lo == OPL_BIT)
        begin
          nxt_dm_wdata = bit_wdata;
          nxt_dm_wr    = 1'b1;
          nxt_state    = S_WR;
        end
        else
        begin
          exec   = 1'b1;
          nxt_pc = pc_ff + ((lo == OPL_ALU_IND) ? LEN1 : LEN2);
          done   = 1'b1;
        end
      end
      S_WR:
      begin
        nxt_pc = pc_ff + LEN2;
        done   = 1'b1;
      end
      S_PAD: done = 1'b1;
      S_HALT:
      begin
        if (WAKE_I)
        begin
          nxt_stop  = 1'b0;
          nxt_wait  = 1'b0;
          nxt_state = S_FETCH;
        end
      end
      default:
      begin
        nxt_state = S_PAD;
      end
    endcase
    if (exec)
    begin
      nxt_acc = alu_wr ? alu_res : acc_ff;
      nxt_z   = (alu_res == 8'h00);
      nxt_c   = alu_c;
    end
    // padding keeps every instruction except stop and wait at its fixed cycle count
    if (done)
      nxt_state = (cyc_ff == need_ff - 3'h1) ? S_FETCH : S_PAD;
    if (nxt_state == S_FETCH)
    begin
      nxt_pm_addr = nxt_pc;
      nxt_pm_rd   = 1'b1;
      nxt_cyc     = 3'h0;
    end
  end

  // reset parks in pad with a one-cycle length so the first fetch follows
  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      state_ff    <= S_PAD;
      cyc_ff      <= 3'h0;
      need_ff     <= 3'h1;
      pc_ff       <= RESET_PC;
      op_ff       <= 8'h00;
      acc_ff      <= 8'h00;
      z_ff        <= 1'b0;
      c_ff        <= 1'b0;
      sz_ff       <= 1'b0;
      sc_ff       <= 1'b0;
      pm_addr_ff  <= RESET_PC;
      pm_rd_ff    <= 1'b0;
      dm_addr_ff  <= 8'h00;
      dm_rd_ff    <= 1'b0;
      dm_wr_ff    <= 1'b0;
      dm_wdata_ff <= 8'h00;
      push_ff     <= 1'b0;
      pop_ff      <= 1'b0;
      stk_ff      <= 12'h000;
      stop_ff     <= 1'b0;
      wait_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cyc_ff      <= nxt_cyc;
      need_ff     <= nxt_need;
      pc_ff       <= nxt_pc;
      op_ff       <= nxt_op;
      acc_ff      <= nxt_acc;
      z_ff        <= nxt_z;
      c_ff        <= nxt_c;
      sz_ff       <= nxt_sz;
      sc_ff       <= nxt_sc;
      pm_addr_ff  <= nxt_pm_addr;
      pm_rd_ff    <= nxt_pm_rd;
      dm_addr_ff  <= nxt_dm_addr;
      dm_rd_ff    <= nxt_dm_rd;
      dm_wr_ff    <= nxt_dm_wr;
      dm_wdata_ff <= nxt_dm_wdata;
      push_ff     <= nxt_push;
      pop_ff      <= nxt_pop;
      stk_ff      <= nxt_stk;
      stop_ff     <= nxt_stop;
      wait_ff     <= nxt_wait;
    end
  end

  assign PM_ADDR_O     = pm_addr_ff;
  assign PM_RD_O       = pm_rd_ff;
  assign DM_ADDR_O     = dm_addr_ff;
  assign DM_RD_O       = dm_rd_ff;
  assign DM_WR_O       = dm_wr_ff;
  assign DM_WDATA_O    = dm_wdata_ff;
  assign STACK_PUSH_O  = push_ff;
  assign STACK_POP_O   = pop_ff;
  assign STACK_WDATA_O = stk_ff;
  assign STOP_O        = stop_ff;
  assign WAIT_O        = wait_ff;
  assign ACC_O         = acc_ff;
  assign ZERO_O        = z_ff;
  assign CARRY_O       = c_ff;

  // ***************************************************************
  // checks
  // ***************************************************************
  a_acc_result:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      exec && alu_wr |=> acc_ff == $past(alu_res)) else $error("accumulator not updated");
  a_cmp_keeps_acc:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      exec && alu_fn == ALU_CMP |=> $stable(acc_ff)) else $error("compare changed acc");
  a_inh_no_mem:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && lo == OPL_INH |=> !DM_RD_O && !DM_WR_O) else $error("inherent op hit memory");
  a_pcr_branch:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && is_pcr |=> pc_ff == ($past(pcr_ok) ? $past(pcr_tgt) : $past(pc_ff) + LEN1))
      else $error("flag branch target wrong");
  a_pcr_span:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && is_pcr && pcr_ok && op_ff[7:3] == 5'h0F |=> pc_ff == $past(pc_ff) + 12'h010)
      else $error("flag branch span wrong");
  a_btb_taken:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_MEM && lo == OPL_BTB && tested_bit == op_ff[4] |=> pc_ff == $past(btb_tgt))
      else $error("bit branch target wrong");
  a_btb_carry:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_MEM && lo == OPL_BTB |=> c_ff == $past(tested_bit) && $stable(z_ff))
      else $error("bit branch flags wrong");
  a_bit_write:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_MEM && lo == OPL_BIT |=> DM_WR_O && $stable(z_ff) && $stable(c_ff)
      ##1 state_ff == S_FETCH) else $error("bit write or length wrong");
  a_bit_index:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_MEM && lo == OPL_BIT
      |=> ((DM_WDATA_O ^ $past(DM_RDATA_I)) & ~$past(bit_mask)) == 8'h00
      && DM_WDATA_O[$past(bit_idx)] == $past(op_ff[4])) else $error("wrong bit modified");
  a_stop_wdg:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && lo == OPL_INH && hi == INH_STOP && WDG_SEL_I |=> WAIT_O && !STOP_O)
      else $error("stop not replaced by wait");
  a_jump_target:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && (lo == OPL_JP || lo == OPL_CALL) |=> pc_ff == {$past(hi), $past(PM_DATA_I)})
      else $error("jump target wrong");
  a_zero_flag:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      exec |=> z_ff == ($past(alu_res) == 8'h00)) else $error("zero flag wrong");
  a_return_from_interrupt_flags:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && lo == OPL_INH && hi == INH_RETURN_FROM_INTERRUPT |=> z_ff == $past(sz_ff) && c_ff == $past(sc_ff))
      else $error("flags not restored");
  a_ret_flags:
    assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      state_ff == S_DEC && lo == OPL_INH && hi == INH_RET |=> $stable(z_ff) && $stable(c_ff))
      else $error("return changed flags");

endmodule : cie_core
